// ### verilog/pmc_defs.svh
// Constant definitions for the power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_ADDR_MODE      8'h00
`define PMC_ADDR_ACT_TPL   8'h04
`define PMC_ADDR_ALT_TPL   8'h08
`define PMC_ADDR_WAKE_EN   8'h0C
`define PMC_ADDR_CTW       8'h10
`define PMC_ADDR_STATUS    8'h14
`define PMC_TPL_RESET      8'hFF
`define PMC_WAKE_RESET     4'h0
`define PMC_CPU_BIT        0
`define PMC_WAKE_PERIPH    0
`define PMC_WAKE_SUPPLY    1
`define PMC_WAKE_CTW       2
`define PMC_WAKE_PIN       3
`define PMC_CTW_TAP        9
`define PMC_CLK_MHZ        25
`define PMC_SLEEP_US       15
`define PMC_HIB_US         100
`define PMC_RESP_OKAY      2'h0
`define PMC_RESP_SLVERR    2'h2
`endif

// ### verilog/pmc_pkg.sv
// Types shared by the power mode controller
`default_nettype none
package pmc_pkg;
  // Global power modes, Gray coded along active-alternate-sleep-hibernate-resume order
  typedef enum logic [2:0] {
    PMC_ACTIVE    = 3'h0,
    PMC_ALTERNATE = 3'h1,
    PMC_SLEEP     = 3'h3,
    PMC_HIBERNATE = 3'h2,
    PMC_RESUME    = 3'h6
  } pmc_mode_e;

  // Wakeup request sources
  typedef struct packed {
    logic peripheral;
    logic supply;
    logic pin;
  } pmc_wake_s;

  // Reset-type wakeup sources
  typedef struct packed {
    logic ext_pin;
    logic watchdog;
    logic precise;
  } pmc_rst_s;
endpackage : pmc_pkg
`default_nettype wire

// ### verilog/pmc_ctrl.sv
// Power mode controller with AXI4-Lite register access
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "pmc_defs.svh"
`default_nettype none
// Functional notes
// - Four modes: active, alternate, sleep, hibernate
// - Active by wakeup, reset, write; alternate write-only
// - Active template bits enable each subsystem
// - Disabled resource: clocks gated, bias cut
// - CPU may disable itself; wakeup re-enables
// - Wakeup forces active mode and CPU on
// - Boots into active mode
// - Alternate mode uses own template
// - Sleep/hibernate by write; all subsystems off
// - Sleep keeps timewheel and real-time clock running
// - Sleep resume waits regulators, within 15 us
// - Hibernate stops clocks, wakes on pin interrupt or reset-type source
// - Hibernate holds outputs and pin interrupt setup
// - Hibernate resume under 100 us
// - Wakeups from interrupt or reset restore active
// - Timewheel gives periodic wakeup interrupts
// - Reset pin, watchdog, precise reset wake
// - Timewheel: 13-bit counter at 1 kHz
module pmc_ctrl #(
  parameter int NSUB     = 8,   // Power-controllable subsystems
  parameter int CTW_BITS = 13   // Timewheel width
) (
  input  wire logic             CLOCK,
  input  wire logic             RST,
  input  wire logic             CE,
  input  wire logic             TICK_1K,       // One-cycle pulse from low_speed_osc
  input  wire pmc_pkg::pmc_wake_s WAKE_IRQ,    // Interrupt wakeup sources
  input  wire pmc_pkg::pmc_rst_s  WAKE_RST,    // Reset-type wakeup sources
  input  wire logic             REG_READY,     // Regulators stable
  input  wire logic             AWVALID,
  output logic                  AWREADY,
  input  wire logic [7:0]       AWADDR,
  input  wire logic             WVALID,
  output logic                  WREADY,
  input  wire logic [31:0]      WDATA,
  input  wire logic [3:0]       WSTRB,
  output logic                  BVALID,
  input  wire logic             BREADY,
  output logic [1:0]            BRESP,
  input  wire logic             ARVALID,
  output logic                  ARREADY,
  input  wire logic [7:0]       ARADDR,
  output logic                  RVALID,
  input  wire logic             RREADY,
  output logic [31:0]           RDATA,
  output logic [1:0]            RRESP,
  output logic [NSUB-1:0]       SUB_CLK_EN,    // Clock enable per subsystem
  output logic [NSUB-1:0]       SUB_BIAS_EN,   // Bias/leakage enable per subsystem
  output logic                  SLOW_CLK_ONLY, // Only slow oscillators may run
  output logic                  ALL_CLK_STOP,  // Hibernate clock stop
  output logic                  IO_HOLD,       // Freeze pin outputs and pin irq setup
  output logic [2:0]            MODE           // Current global mode
);
  // Resume times in cycles, rounded down (longest allowed)
  localparam int SLEEP_CYC = `PMC_SLEEP_US * `PMC_CLK_MHZ;
  localparam int HIB_CYC   = `PMC_HIB_US * `PMC_CLK_MHZ;
  localparam int CW        = 12;

  pmc_pkg::pmc_mode_e mode_reg, mode_next;  // Global mode
  logic [NSUB-1:0]    act_tpl_reg;          // Active template
  logic [NSUB-1:0]    alt_tpl_reg;          // Alternate template
  logic [3:0]         wake_en_reg;          // Wakeup source enables
  logic [CTW_BITS-1:0] ctw_reg;             // Central timewheel
  logic [CTW_BITS-1:0] ctw_next;
  logic [CW-1:0]      rcnt_reg, rcnt_next;  // Resume deadline counter
  logic               hib_resume_reg;       // Resume started from hibernate
  logic               cpu_force_reg;        // CPU re-enabled by wakeup
  logic               aw_hold_reg, w_hold_reg;
  logic [7:0]         awaddr_reg;
  logic [31:0]        wdata_reg;
  logic               rst_wake_reg;         // Reset-type wake seen

  // Bus decode
  wire aw_take  = AWVALID && AWREADY;
  wire w_take   = WVALID && WREADY;
  wire wr_go    = (aw_hold_reg || aw_take) && (w_hold_reg || w_take) && !BVALID;
  wire [7:0] wa = aw_take ? AWADDR : awaddr_reg;
  wire [31:0] wd = w_take ? WDATA : wdata_reg;
  wire wr_mode  = wr_go && wa == `PMC_ADDR_MODE && WSTRB[0];
  wire wr_act   = wr_go && wa == `PMC_ADDR_ACT_TPL && WSTRB[0];
  wire wr_alt   = wr_go && wa == `PMC_ADDR_ALT_TPL && WSTRB[0];
  wire wr_wen   = wr_go && wa == `PMC_ADDR_WAKE_EN && WSTRB[0];
  wire wr_ctw   = wr_go && wa == `PMC_ADDR_CTW;
  wire wr_ok    = wa == `PMC_ADDR_MODE || wa == `PMC_ADDR_ACT_TPL
               || wa == `PMC_ADDR_ALT_TPL || wa == `PMC_ADDR_WAKE_EN
               || wa == `PMC_ADDR_CTW;
  wire [2:0] req_mode = wd[2:0];

  // Timewheel wraps; tap bit gives periodic interrupt
  wire ctw_run  = mode_reg != pmc_pkg::PMC_HIBERNATE;
  wire ctw_irq  = ctw_run && TICK_1K && (ctw_reg[`PMC_CTW_TAP:0] == '1);

  // Wakeup qualification per mode
  wire wk_per   = WAKE_IRQ.peripheral && wake_en_reg[`PMC_WAKE_PERIPH];
  wire wk_sup   = WAKE_IRQ.supply && wake_en_reg[`PMC_WAKE_SUPPLY];
  wire wk_ctw   = ctw_irq && wake_en_reg[`PMC_WAKE_CTW];
  wire wk_pin   = WAKE_IRQ.pin && wake_en_reg[`PMC_WAKE_PIN];
  wire rst_any  = |WAKE_RST;
  wire wake_irq_any = (mode_reg == pmc_pkg::PMC_HIBERNATE) ? wk_pin
                    : (wk_per || wk_sup || wk_ctw || wk_pin);
  wire wake_any = wake_irq_any || rst_any;

  // Mode sequencing
  always_comb
  begin
    mode_next = mode_reg;
    rcnt_next = rcnt_reg;
    case (mode_reg)
      pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_ALTERNATE:
      begin
        if (wake_any)
          mode_next = pmc_pkg::PMC_ACTIVE;
        else if (wr_mode)
        begin
          // Only the four documented modes; others ignored
          if (req_mode == pmc_pkg::PMC_ACTIVE || req_mode == pmc_pkg::PMC_ALTERNATE
              || req_mode == pmc_pkg::PMC_SLEEP || req_mode == pmc_pkg::PMC_HIBERNATE)
            mode_next = pmc_pkg::pmc_mode_e'(req_mode);
        end
      end
      pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_HIBERNATE:
      begin
        // Mode writes here are ignored
        if (wake_any)
        begin
          mode_next = pmc_pkg::PMC_RESUME;
          rcnt_next = '0;
        end
      end
      pmc_pkg::PMC_RESUME:
      begin
        // Leave once regulators settle, or at the deadline regardless
        rcnt_next = rcnt_reg + CW'(1);
        if (REG_READY || (hib_resume_reg ? rcnt_reg >= CW'(HIB_CYC - 2)
                                         : rcnt_reg >= CW'(SLEEP_CYC - 2)))
          mode_next = pmc_pkg::PMC_ACTIVE;
      end
      default:
        mode_next = pmc_pkg::PMC_ACTIVE;
    endcase
  end

  assign ctw_next = (wr_ctw ? '0 : ctw_reg) + ((ctw_run && TICK_1K) ? CTW_BITS'(1) : '0);

  // Mode, resume and timewheel state
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      mode_reg       <= pmc_pkg::PMC_ACTIVE;
      rcnt_reg       <= '0;
      hib_resume_reg <= 1'b0;
      ctw_reg        <= '0;
      rst_wake_reg   <= 1'b0;
    end
    else if (CE)
    begin
      mode_reg       <= mode_next;
      rcnt_reg       <= rcnt_next;
      if (mode_next == pmc_pkg::PMC_RESUME && mode_reg != pmc_pkg::PMC_RESUME)
        hib_resume_reg <= mode_reg == pmc_pkg::PMC_HIBERNATE;
      ctw_reg        <= ctw_next;
      if (rst_any)
        rst_wake_reg <= 1'b1;
      else if (wr_go && wa == `PMC_ADDR_STATUS)
        rst_wake_reg <= 1'b0;
    end
  end

  // Templates, wake enables, CPU override
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      act_tpl_reg   <= `PMC_TPL_RESET;
      alt_tpl_reg   <= `PMC_TPL_RESET;
      wake_en_reg   <= `PMC_WAKE_RESET;
      cpu_force_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (wr_act)
        act_tpl_reg <= wd[NSUB-1:0];
      if (wr_alt)
        alt_tpl_reg <= wd[NSUB-1:0];
      if (wr_wen)
        wake_en_reg <= wd[3:0];
      // Wakeup sets the override; a template write to the CPU bit ends it
      if (wake_any)
        cpu_force_reg <= 1'b1;
      else if (wr_act || wr_alt)
        cpu_force_reg <= 1'b0;
    end
  end

  // Subsystem gating from the selected template
  wire [NSUB-1:0] tpl = (mode_reg == pmc_pkg::PMC_ALTERNATE) ? alt_tpl_reg
                      : (mode_reg == pmc_pkg::PMC_ACTIVE)    ? act_tpl_reg
                      : '0;
  wire [NSUB-1:0] cpu_mask = NSUB'(cpu_force_reg) << `PMC_CPU_BIT;
  wire [NSUB-1:0] en_next  = tpl | (tpl == '0 && mode_reg != pmc_pkg::PMC_ACTIVE
                                    && mode_reg != pmc_pkg::PMC_ALTERNATE ? '0 : cpu_mask);

  // Registered gating outputs
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      SUB_CLK_EN    <= `PMC_TPL_RESET;
      SUB_BIAS_EN   <= `PMC_TPL_RESET;
      SLOW_CLK_ONLY <= 1'b0;
      ALL_CLK_STOP  <= 1'b0;
      IO_HOLD       <= 1'b0;
      MODE          <= pmc_pkg::PMC_ACTIVE;
    end
    else if (CE)
    begin
      SUB_CLK_EN    <= en_next;
      SUB_BIAS_EN   <= en_next;
      SLOW_CLK_ONLY <= mode_reg == pmc_pkg::PMC_SLEEP;
      ALL_CLK_STOP  <= mode_reg == pmc_pkg::PMC_HIBERNATE;
      IO_HOLD       <= mode_reg == pmc_pkg::PMC_HIBERNATE;
      MODE          <= mode_reg;
    end
  end

  // Write channel: capture address and data in either order
  assign AWREADY = !aw_hold_reg && !BVALID;
  assign WREADY  = !w_hold_reg && !BVALID;
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      BVALID      <= 1'b0;
      BRESP       <= `PMC_RESP_OKAY;
    end
    else if (CE)
    begin
      if (wr_go)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        BVALID      <= 1'b1;
        BRESP       <= (wr_ok || wa == `PMC_ADDR_STATUS) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_hold_reg <= 1'b1;
          awaddr_reg  <= AWADDR;
        end
        if (w_take)
        begin
          w_hold_reg <= 1'b1;
          wdata_reg  <= WDATA;
        end
        if (BVALID && BREADY)
          BVALID <= 1'b0;
      end
    end
  end

  // Read channel
  assign ARREADY = !RVALID;
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      RVALID <= 1'b0;
      RDATA  <= '0;
      RRESP  <= `PMC_RESP_OKAY;
    end
    else if (CE)
    begin
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RRESP  <= `PMC_RESP_OKAY;
        if (ARADDR == `PMC_ADDR_MODE)
          RDATA <= 32'(mode_reg);
        else if (ARADDR == `PMC_ADDR_ACT_TPL)
          RDATA <= 32'(act_tpl_reg);
        else if (ARADDR == `PMC_ADDR_ALT_TPL)
          RDATA <= 32'(alt_tpl_reg);
        else if (ARADDR == `PMC_ADDR_WAKE_EN)
          RDATA <= 32'(wake_en_reg);
        else if (ARADDR == `PMC_ADDR_CTW)
          RDATA <= 32'(ctw_reg);
        else if (ARADDR == `PMC_ADDR_STATUS)
          RDATA <= {30'h0, cpu_force_reg, rst_wake_reg};
        else
        begin
          RDATA <= '0;
          RRESP <= `PMC_RESP_SLVERR;
        end
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
    end
  end

  // Checks
  hib_pin_only_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && mode_reg == pmc_pkg::PMC_HIBERNATE && !wk_pin && !rst_any
    |=> mode_reg == pmc_pkg::PMC_HIBERNATE)
    else $error("hibernate left without pin wakeup");
  wake_active_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wake_any && (mode_reg == pmc_pkg::PMC_ACTIVE || mode_reg == pmc_pkg::PMC_ALTERNATE)
    |=> mode_reg == pmc_pkg::PMC_ACTIVE)
    else $error("wakeup did not force active");
  sleep_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && mode_reg == pmc_pkg::PMC_SLEEP |=> SUB_CLK_EN == '0 && SLOW_CLK_ONLY)
    else $error("sleep left subsystems on");
  sleep_resume_a: assert property (@(posedge CLOCK) disable iff (RST)
    mode_reg == pmc_pkg::PMC_RESUME && !hib_resume_reg && rcnt_reg == CW'(SLEEP_CYC - 2) && CE
    |=> mode_reg == pmc_pkg::PMC_ACTIVE)
    else $error("sleep resume too slow");
  hib_resume_a: assert property (@(posedge CLOCK) disable iff (RST)
    mode_reg == pmc_pkg::PMC_RESUME && hib_resume_reg |-> rcnt_reg <= CW'(HIB_CYC - 2))
    else $error("hibernate resume too slow");
  ignore_req_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && mode_reg == pmc_pkg::PMC_SLEEP && !wake_any |=> mode_reg == pmc_pkg::PMC_SLEEP)
    else $error("write changed mode in sleep");
  hold_io_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && mode_reg == pmc_pkg::PMC_HIBERNATE |=> IO_HOLD && ALL_CLK_STOP)
    else $error("pins not held in hibernate");
  ctw_step_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && TICK_1K && ctw_run && !wr_ctw |=> ctw_reg == $past(ctw_reg) + CTW_BITS'(1))
    else $error("timewheel did not advance");
  cpu_on_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wake_any && !(wr_act || wr_alt) ##1 CE && mode_reg == pmc_pkg::PMC_ACTIVE
    |=> SUB_CLK_EN[`PMC_CPU_BIT])
    else $error("cpu not re-enabled");
  sleep_c: cover property (@(posedge CLOCK) mode_reg == pmc_pkg::PMC_SLEEP ##[1:400]
    mode_reg == pmc_pkg::PMC_ACTIVE);
  hib_c: cover property (@(posedge CLOCK) mode_reg == pmc_pkg::PMC_HIBERNATE ##1
    mode_reg == pmc_pkg::PMC_RESUME);
  alt_c: cover property (@(posedge CLOCK) mode_reg == pmc_pkg::PMC_ALTERNATE);
endmodule : pmc_ctrl
`default_nettype wire

// ### testbench/tb_pmc_ctrl.sv
// Self-checking bench for the power mode controller
`include "pmc_defs.svh"
`default_nettype none
module tb_pmc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock = 1'b0;   // 25 MHz system clock
  logic               rst = 1'b1;     // Asynchronous reset
  logic               tick = 1'b0;    // Timewheel tick pulse, one cycle in three
  logic               reg_ok = 1'b1;  // Regulators stable
  logic               ce = 1'b1;      // Clock enable, dropped once to freeze state
  pmc_pkg::pmc_wake_s wirq = '0;      // Interrupt wake sources
  pmc_pkg::pmc_rst_s  wrst = '0;      // Reset-type wake sources
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic [3:0]         wstrb = 4'h0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [1:0]         bseen = 2'h0;   // Response of the last write
  logic [31:0]        rdata;
  logic [7:0]         sub_clk, sub_bias;  // Per-subsystem enables
  logic               slow, stop, hold;
  logic [2:0]         mode;
  int                 n_mismatch = 0;
  int                 compares = 0;

  pmc_ctrl DUT (.CLOCK(clock), .RST(rst), .CE(ce), .TICK_1K(tick), .WAKE_IRQ(wirq),
    .WAKE_RST(wrst), .REG_READY(reg_ok), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
    .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .SUB_CLK_EN(sub_clk), .SUB_BIAS_EN(sub_bias), .SLOW_CLK_ONLY(slow),
    .ALL_CLK_STOP(stop), .IO_HOLD(hold), .MODE(mode));

  // Free-running clock
  always #20 clock = ~clock;

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cm(input logic [2:0] m);
    chk("mode", 32'(mode), 32'(m));
  endtask : cm

  // Wait n edges, then sample at the settled falling edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : step

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    while (!tb)
    begin
      @(negedge clock);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      tb = bready & bvalid;
      if (tb) bseen = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= ta & tw & !tb;
    end
  endtask : wr

  // Read: data and response sampled at the falling edge before the rvalid handshake edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tk, dn;
    tk = 1'b0;
    dn = 1'b0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr  <= a;
    while (!dn)
    begin
      @(negedge clock);
      tk = tk | (arvalid & arready);
      dn = rready & rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clock);
      if (tk) arvalid <= 1'b0;
      rready <= tk & !dn;
    end
  endtask : rd

  // One-cycle pulses from the slow oscillator, spaced out
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clock);
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
      @(posedge clock);
    end
  endtask : ticks

  // Interrupt wake held for one cycle
  task automatic hit(input logic [2:0] v);
    @(posedge clock);
    wirq <= pmc_pkg::pmc_wake_s'(v);
    @(posedge clock);
    wirq <= '0;
  endtask : hit

  task automatic wait_mode(input logic [2:0] m, input int lim, output int n);
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(negedge clock);
      n++;
    end
  endtask : wait_mode

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Watchdog: the tests need well under 10000 cycles
  initial
  begin
    #(40 * 20000);
    n_mismatch++;
    close_out();
  end

  // Test sequence
  initial
  begin
    int n;
    logic [31:0] d, e;
    logic [1:0] r;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    step(1);
    cm(pmc_pkg::PMC_ACTIVE);
    chk("clk_en", 32'(sub_clk), 32'hFF);
    chk("hold", 32'(hold), 32'h0);
    rd(`PMC_ADDR_WAKE_EN, d, r);
    chk("wake_en", d, 32'h0);
    rd(8'h3C, d, r);
    chk("unmapped", 32'(r), 32'(`PMC_RESP_SLVERR));
    wr(8'h3C, 32'h0);
    chk("bresp", 32'(bseen), 32'(`PMC_RESP_SLVERR));
    $display("test boot done");
    // CPU turns itself off, each reset-type source brings it back
    for (int i = 0; i < 3; i++)
    begin
      wr(`PMC_ADDR_ACT_TPL, 32'h0E);
      step(3);
      chk("clk_en", 32'(sub_clk), 32'h0E);
      chk("bias_en", 32'(sub_bias), 32'h0E);
      @(posedge clock);
      wrst <= pmc_pkg::pmc_rst_s'(3'b001 << i);
      @(posedge clock);
      wrst <= '0;
      step(3);
      chk("clk_en", 32'(sub_clk), 32'h0F);
    end
    rd(`PMC_ADDR_STATUS, d, r);
    chk("status", 32'(d[0]), 32'h1);
    chk("cpu_force", 32'(d[1]), 32'h1);
    wr(`PMC_ADDR_STATUS, 32'h0);
    chk("bresp", 32'(bseen), 32'(`PMC_RESP_OKAY));
    rd(`PMC_ADDR_STATUS, d, r);
    chk("status_clr", 32'(d[0]), 32'h0);
    $display("test reset wake done");
    // Alternate mode uses its own template; wake returns to active
    wr(`PMC_ADDR_ALT_TPL, 32'hF0);
    wr(`PMC_ADDR_WAKE_EN, 32'hB);
    wr(`PMC_ADDR_MODE, 32'(pmc_pkg::PMC_ALTERNATE));
    step(3);
    cm(pmc_pkg::PMC_ALTERNATE);
    chk("clk_en", 32'(sub_clk), 32'hF0);
    hit(3'b100);
    step(3);
    cm(pmc_pkg::PMC_ACTIVE);
    chk("clk_en", 32'(sub_clk), 32'h0F);
    $display("test alternate done");
    // Sleep: everything off, mode writes ignored, slow resume
    wr(`PMC_ADDR_MODE, 32'(pmc_pkg::PMC_SLEEP));
    step(3);
    cm(pmc_pkg::PMC_SLEEP);
    chk("clk_en", 32'(sub_clk), 32'h00);
    chk("slow", 32'(slow), 32'h1);
    wr(`PMC_ADDR_MODE, 32'(pmc_pkg::PMC_HIBERNATE));
    step(3);
    cm(pmc_pkg::PMC_SLEEP);
    @(posedge clock);
    reg_ok <= 1'b0;
    hit(3'b010);
    wait_mode(pmc_pkg::PMC_ACTIVE, 500, n);
    chk("sleep_resume", 32'(n >= 300 && n <= 377), 32'h1);
    step(2);
    chk("clk_en", 32'(sub_clk), 32'h0F);
    @(posedge clock);
    reg_ok <= 1'b1;
    $display("test sleep done");
    // Timewheel counts ticks and wakes from sleep every 1024
    wr(`PMC_ADDR_CTW, 32'h0);
    ticks(5);
    rd(`PMC_ADDR_CTW, d, r);
    chk("ctw", d, 32'h5);
    // Clock enable low: ticks must be lost, count stays put
    @(posedge clock);
    ce <= 1'b0;
    ticks(2);
    ce <= 1'b1;
    rd(`PMC_ADDR_CTW, d, r);
    chk("ctw_frozen", d, 32'h5);
    wr(`PMC_ADDR_WAKE_EN, 32'hF);
    wr(`PMC_ADDR_MODE, 32'(pmc_pkg::PMC_SLEEP));
    ticks(1018);
    cm(pmc_pkg::PMC_SLEEP);
    ticks(1);
    step(4);
    cm(pmc_pkg::PMC_ACTIVE);
    $display("test timewheel done");
    // Hibernate: clocks stop, pins held, only pin interrupt wakes
    wr(`PMC_ADDR_MODE, 32'(pmc_pkg::PMC_HIBERNATE));
    step(3);
    cm(pmc_pkg::PMC_HIBERNATE);
    chk("stop", 32'(stop), 32'h1);
    chk("hold", 32'(hold), 32'h1);
    chk("clk_en", 32'(sub_clk), 32'h00);
    rd(`PMC_ADDR_CTW, e, r);
    ticks(3);
    rd(`PMC_ADDR_CTW, d, r);
    chk("ctw", d, e);
    hit(3'b100);
    step(6);
    cm(pmc_pkg::PMC_HIBERNATE);
    hit(3'b001);
    wait_mode(pmc_pkg::PMC_ACTIVE, 3000, n);
    chk("hib_resume", 32'(n < 2500), 32'h1);
    step(2);
    chk("hold", 32'(hold), 32'h0);
    // Regulators never settle: resume must still end by the deadline
    wr(`PMC_ADDR_MODE, 32'(pmc_pkg::PMC_HIBERNATE));
    step(3);
    cm(pmc_pkg::PMC_HIBERNATE);
    @(posedge clock);
    reg_ok <= 1'b0;
    hit(3'b001);
    wait_mode(pmc_pkg::PMC_ACTIVE, 3000, n);
    chk("hib_deadline", 32'(n >= 2000 && n <= 2501), 32'h1);
    $display("test hibernate done");
    close_out();
  end
endmodule : tb_pmc_ctrl
`default_nettype wire
